// file: design/dem_ext_mode_act.sv
// Top of the DDR2 extended mode, activate and posted-CAS command logic.
`timescale 1ns/100ps
// How it works
// - All strobes low with bank code one writes extended mode register one.
// - Register one fields: DLL, drive, additive latency, termination, strobe disable.
// - Mode writes are taken only while every bank is precharged.
// - Self-refresh turns the DLL off; leaving it turns the DLL on unless register one disables it.
// - All strobes low with bank code two writes extended mode register two.
// - Termination is off throughout self-refresh regardless of its pin.
// - Activate decodes on its strobes; bank and row come from address pins.
// - Column commands are accepted from the clock after activate.
// - Column command decodes on its strobes; write enable picks direction.
// - A burst of four stays inside its aligned four-column segment.
// - Column commands wait the additive latency; read and write latencies follow.
module dem_ext_mode_act #(
  parameter int MAX_AL = 6
) (
  // Clock and reset.
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  // Command pins, sampled on the rising clock.
  input  wire logic                         cke,
  input  wire logic                         csN,
  input  wire logic                         rasN,
  input  wire logic                         casN,
  input  wire logic                         weN,
  input  wire logic [dem_pkg::BA_W-1:0]     ba,
  input  wire logic [dem_pkg::ADDR_W-1:0]   addr,
  input  wire logic                         odtPin,
  // Settings held in the base mode register outside this block.
  input  wire logic [dem_pkg::AL_W-1:0]     casLatency,
  input  wire logic                         burstInterleave,
  // Extended mode register contents and decoded fields.
  output logic [dem_pkg::ADDR_W-1:0]        extMode1,
  output logic [dem_pkg::ADDR_W-1:0]        extMode2,
  output logic [dem_pkg::ADDR_W-1:0]        extMode3,
  output logic                              dllEnabled,
  output logic                              dllLocked,
  output logic                              driveWeak,
  output logic [1:0]                        odtSetting,
  output logic [dem_pkg::AL_W-1:0]          addLatency,
  output logic                              strobeCompDisabled,
  output logic                              alReserved,
  // Power and termination state.
  output logic                              selfRefresh,
  output logic                              termActive,
  // Bank state.
  output logic [dem_pkg::NBANK-1:0]         bankOpen,
  // Latencies.
  output logic [dem_pkg::LAT_W-1:0]         readLatency,
  output logic [dem_pkg::LAT_W-1:0]         writeLatency,
  // Internally issued column command.
  output logic                              issueValid,
  output logic                              issueWrite,
  output logic [dem_pkg::BA_W-1:0]          issueBank,
  output logic [dem_pkg::ADDR_W-1:0]        issueRow,
  output logic [dem_pkg::SEG_W-1:0]         issueSegment,
  output logic [2*dem_pkg::BURST4-1:0]      burstCols,
  // Error pulses.
  output logic                              modeRejected,
  output logic                              modeReservedSet,
  output logic                              modeWithTerm,
  output logic                              colToClosed,
  output logic                              colTooClose,
  output logic                              readBeforeLock
);
  localparam int NB  = dem_pkg::NBANK;
  localparam int AW  = dem_pkg::ADDR_W;
  localparam int LW  = dem_pkg::LAT_W;
  localparam int LKW = dem_pkg::LOCK_W;
  localparam logic [LKW-1:0] LOCK_CNT = LKW'(dem_pkg::DLL_LOCK_CK);
  localparam logic [1:0]     CCD_CNT  = 2'(dem_pkg::TCCD_CK - 1);

  typedef struct packed {
    logic                         ckePrev;
    logic                         selfRef;
    logic [AW-1:0]                emr1;
    logic [AW-1:0]                emr2;
    logic [AW-1:0]                emr3;
    logic [NB-1:0]                open;
    logic [NB-1:0][AW-1:0]        row;
    logic                         dll;
    logic [LKW-1:0]               lockCnt;
    logic                         locked;
    logic                         term;
    logic                         alRsvd;
    logic [LW-1:0]                rdLat;
    logic [LW-1:0]                wrLat;
    logic [1:0]                   ccdCnt;
    dem_pkg::dem_col_t            iss;
    logic [AW-1:0]                issRow;
    logic [dem_pkg::BURST4-1:0][1:0] order;
    logic                         rej;
    logic                         rsvdSet;
    logic                         modeTerm;
    logic                         closedCol;
    logic                         tooClose;
    logic                         earlyRead;
  } dem_top_state_t;

  dem_top_state_t    stateQ;
  dem_top_state_t    stateD;
  dem_pkg::dem_cmd_t cmd;
  logic              live;
  logic              modeWrite;
  logic [2:0]        alRaw;
  logic [2:0]        alEff;

  dem_col_if colNew ();
  dem_col_if colIss ();

  // Commands count only with clock enable high on this and the last edge.
  assign live = cke && stateQ.ckePrev && !stateQ.selfRef;

  // Pin decoder; column commands are gated by the live condition.
  dem_cmd_decode uDecode (
    .csN    (csN),
    .rasN   (rasN),
    .casN   (casN),
    .weN    (weN),
    .ba     (ba),
    .addr   (addr),
    .colEn  (live),
    .cmd    (cmd),
    .colOut (colNew.src)
  );

  // reserved code runs at the longest latency
  assign alRaw = stateQ.emr1[dem_pkg::E1_AL_HI:dem_pkg::E1_AL_LO];
  assign alEff = (alRaw == dem_pkg::AL_RSVD) ? dem_pkg::AL_MAX : alRaw;

  // Posted-CAS delay for column commands.
  dem_posted_cas #(
    .MAX_AL (MAX_AL)
  ) uPosted (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .al     (alEff),
    .newCmd (colNew.dst),
    .issued (colIss.src)
  );

  // Any of the three extended mode writes.
  assign modeWrite = (cmd == dem_pkg::CMD_EMR1) || (cmd == dem_pkg::CMD_EMR2) ||
                     (cmd == dem_pkg::CMD_EMR3);

  // Next state of the whole block.
  always_comb
  begin
    stateD           = stateQ;
    stateD.ckePrev   = cke;
    stateD.rej       = 1'b0;
    stateD.rsvdSet   = 1'b0;
    stateD.modeTerm  = 1'b0;
    stateD.closedCol = 1'b0;
    stateD.tooClose  = 1'b0;
    stateD.earlyRead = 1'b0;

    // refresh with clock enable falling enters self-refresh
    if (!stateQ.selfRef && stateQ.ckePrev && !cke && cmd == dem_pkg::CMD_REF && !csN)
      stateD.selfRef = 1'b1;
    else if (stateQ.selfRef && cke)
      stateD.selfRef = 1'b0;

    // Lock wait counts down while the DLL runs; self-refresh exit keeps lock.
    // It sits ahead of the command decode so that a fresh DLL reset wins.
    if (stateQ.lockCnt != '0 && stateQ.dll)
    begin
      stateD.lockCnt = stateQ.lockCnt - LKW'(1);
      stateD.locked  = (stateQ.lockCnt == LKW'(1));
    end

    if (live)
    begin
      unique case (cmd)
        dem_pkg::CMD_EMR1,
        dem_pkg::CMD_EMR2,
        dem_pkg::CMD_EMR3:
        begin
          // refused while any bank is open
          if (stateQ.open != '0)
          begin
            stateD.rej = 1'b1;
          end
          // register one takes the address pins
          else if (cmd == dem_pkg::CMD_EMR1)
          begin
            stateD.emr1 = addr;
          end
          // register two takes the address pins
          else if (cmd == dem_pkg::CMD_EMR2)
          begin
            stateD.emr2 = addr;
            stateD.rsvdSet = (addr & ~dem_pkg::E2_KEEP_MASK) != '0;
          end
          else
          begin
            stateD.emr3 = addr;
            stateD.rsvdSet = addr != '0;
          end
          stateD.modeTerm = modeWrite && (stateQ.term || odtPin);
        end
        dem_pkg::CMD_MRS:
        begin
          // a DLL reset restarts the lock wait
          if (addr[dem_pkg::MR_DLL_RST] && stateQ.open == '0)
          begin
            stateD.lockCnt = LOCK_CNT;
            stateD.locked  = 1'b0;
          end
        end
        dem_pkg::CMD_ACT:
        begin
          // open the bank and latch its row
          stateD.open[ba] = 1'b1;
          stateD.row[ba]  = addr;
        end
        dem_pkg::CMD_PRE:
        begin
          if (addr[dem_pkg::PRE_ALL_BIT])
            stateD.open = '0;
          else
            stateD.open[ba] = 1'b0;
        end
        dem_pkg::CMD_RD,
        dem_pkg::CMD_WR:
        begin
          // accepted from the clock after activate
          stateD.closedCol = !stateQ.open[ba];
          // spacing under two clocks is flagged
          stateD.tooClose  = stateQ.ccdCnt != '0;
          stateD.ccdCnt    = CCD_CNT;
          stateD.earlyRead = (cmd == dem_pkg::CMD_RD) && !stateQ.locked;
        end
        default:
        begin
        end
      endcase
    end

    // The spacing counter runs down one per clock after a column command.
    if (!(live && (cmd == dem_pkg::CMD_RD || cmd == dem_pkg::CMD_WR)) &&
        stateQ.ccdCnt != '0)
      stateD.ccdCnt = stateQ.ccdCnt - 2'h1;

    stateD.dll  = !stateQ.emr1[dem_pkg::E1_DLL_DIS] && !stateD.selfRef;
    stateD.term = odtPin && !stateD.selfRef &&
                  (stateQ.emr1[dem_pkg::E1_RTT0] || stateQ.emr1[dem_pkg::E1_RTT1]);

    // read latency is AL plus CL, write one less
    stateD.alRsvd = (alRaw == dem_pkg::AL_RSVD);
    stateD.rdLat  = {1'b0, alEff} + {1'b0, casLatency};
    stateD.wrLat  = stateD.rdLat - LW'(1);

    // The issued command picks up the row that its bank holds open.
    stateD.iss    = colIss.cmd;
    stateD.issRow = stateQ.row[colIss.cmd.bank];

    // burst order wraps inside the aligned segment
    for (int i = 0; i < dem_pkg::BURST4; i++)
    begin
      if (burstInterleave)
        stateD.order[i] = colIss.cmd.col[1:0] ^ 2'(i);
      else
        stateD.order[i] = colIss.cmd.col[1:0] + 2'(i);
    end
  end

  // State register; one asynchronous reset to constants.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateQ      <= '0;
      stateQ.emr1 <= dem_pkg::EMR_RST;
      stateQ.emr2 <= dem_pkg::EMR_RST;
      stateQ.emr3 <= dem_pkg::EMR_RST;
    end
    else
    begin
      stateQ <= stateD;
    end
  end

  // Outputs, each straight from the state register.
  assign extMode1           = stateQ.emr1;
  assign extMode2           = stateQ.emr2;
  assign extMode3           = stateQ.emr3;
  assign dllEnabled         = stateQ.dll;
  assign dllLocked          = stateQ.locked;
  assign driveWeak          = stateQ.emr1[dem_pkg::E1_DRV_WEAK];
  assign odtSetting         = {stateQ.emr1[dem_pkg::E1_RTT1], stateQ.emr1[dem_pkg::E1_RTT0]};
  assign addLatency         = alRaw;
  assign strobeCompDisabled = stateQ.emr1[dem_pkg::E1_DQSN_DIS];
  assign alReserved         = stateQ.alRsvd;
  assign selfRefresh        = stateQ.selfRef;
  assign termActive         = stateQ.term;
  assign bankOpen           = stateQ.open;
  assign readLatency        = stateQ.rdLat;
  assign writeLatency       = stateQ.wrLat;
  assign issueValid         = stateQ.iss.valid;
  assign issueWrite         = stateQ.iss.write;
  assign issueBank          = stateQ.iss.bank;
  assign issueRow           = stateQ.issRow;
  assign issueSegment       = stateQ.iss.col[dem_pkg::COL_W-1:dem_pkg::SEG_LSB];
  assign burstCols          = stateQ.order;
  assign modeRejected       = stateQ.rej;
  assign modeReservedSet    = stateQ.rsvdSet;
  assign modeWithTerm       = stateQ.modeTerm;
  assign colToClosed        = stateQ.closedCol;
  assign colTooClose        = stateQ.tooClose;
  assign readBeforeLock     = stateQ.earlyRead;
endmodule : dem_ext_mode_act

// file: pkg/dem_pkg.sv
// Shared constants and types for the DDR2 extended mode and activate block.
package dem_pkg;
  // Pin group widths.
  localparam int ADDR_W = 13;
  localparam int BA_W   = 2;
  localparam int NBANK  = 4;
  localparam int COL_W  = 9;
  localparam int AL_W   = 3;
  localparam int LAT_W  = 4;
  localparam int SEG_W  = 7;

  // Bank address codes that pick the mode register being written.
  localparam logic [1:0] BA_MR   = 2'h0;
  localparam logic [1:0] BA_EMR1 = 2'h1;
  localparam logic [1:0] BA_EMR2 = 2'h2;
  localparam logic [1:0] BA_EMR3 = 2'h3;

  // Extended mode register 1 field positions.
  localparam int E1_DLL_DIS  = 0;
  localparam int E1_DRV_WEAK = 1;
  localparam int E1_RTT0     = 2;
  localparam int E1_AL_LO    = 3;
  localparam int E1_AL_HI    = 5;
  localparam int E1_RTT1     = 6;
  localparam int E1_DQSN_DIS = 10;

  // Extended mode register 2 keeps only this bit; others must be zero.
  localparam logic [12:0] E2_KEEP_MASK = 13'h0080;

  // Base mode register DLL reset bit and the all-banks precharge bit.
  localparam int MR_DLL_RST  = 8;
  localparam int PRE_ALL_BIT = 10;

  // Column address split: segment above, burst-4 offset below.
  localparam int SEG_LSB = 2;
  localparam int BURST4  = 4;

  // Additive latency limits; the all-ones code is reserved.
  localparam logic [2:0] AL_MAX  = 3'h6;
  localparam logic [2:0] AL_RSVD = 3'h7;

  // Register values after reset (all fields zero until written).
  localparam logic [12:0] EMR_RST = 13'h0000;

  // Least column-to-column spacing and DLL lock wait, in clocks.
  localparam int TCCD_CK     = 2;
  localparam int DLL_LOCK_CK = 200;
  localparam int LOCK_W      = 8;

  // Decoded command on the pins.
  typedef enum logic [3:0] {
    CMD_NOP,
    CMD_MRS,
    CMD_EMR1,
    CMD_EMR2,
    CMD_EMR3,
    CMD_ACT,
    CMD_RD,
    CMD_WR,
    CMD_PRE,
    CMD_REF
  } dem_cmd_t;

  // A column command travelling through the posted-CAS delay.
  typedef struct packed {
    logic             valid;
    logic             write;
    logic [BA_W-1:0]  bank;
    logic [COL_W-1:0] col;
  } dem_col_t;
endpackage : dem_pkg

// file: pkg/dem_col_if.sv
// Carrier for one column command between the block's own modules.
`timescale 1ns/100ps
interface dem_col_if;
  dem_pkg::dem_col_t cmd;

  modport src (output cmd);
  modport dst (input cmd);
endinterface : dem_col_if

// file: design/dem_cmd_decode.sv
// Decoder from the command pins to a command code and a column command.
`timescale 1ns/100ps
module dem_cmd_decode (
  // Command pins.
  input  wire logic                     csN,
  input  wire logic                     rasN,
  input  wire logic                     casN,
  input  wire logic                     weN,
  input  wire logic [dem_pkg::BA_W-1:0] ba,
  input  wire logic [dem_pkg::ADDR_W-1:0] addr,
  // Column commands pass only while this is high.
  input  wire logic                     colEn,
  // Results.
  output dem_pkg::dem_cmd_t             cmd,
  dem_col_if.src                        colOut
);
  // Truth table of the strobes; a deselected chip sees no command.
  always_comb
  begin
    cmd = dem_pkg::CMD_NOP;
    if (!csN)
    begin
      unique case ({rasN, casN, weN})
        // mode write, bank code picks register
        // bank code two selects register 2
        3'h0:
        begin
          unique case (ba)
            dem_pkg::BA_MR:   cmd = dem_pkg::CMD_MRS;
            dem_pkg::BA_EMR1: cmd = dem_pkg::CMD_EMR1;
            dem_pkg::BA_EMR2: cmd = dem_pkg::CMD_EMR2;
            dem_pkg::BA_EMR3: cmd = dem_pkg::CMD_EMR3;
          endcase
        end
        3'h1: cmd = dem_pkg::CMD_REF;
        3'h2: cmd = dem_pkg::CMD_PRE;
        3'h3: cmd = dem_pkg::CMD_ACT;
        3'h4: cmd = dem_pkg::CMD_WR;
        3'h5: cmd = dem_pkg::CMD_RD;
        // Burst stop is not supported and reads as no operation.
        default: cmd = dem_pkg::CMD_NOP;
      endcase
    end
  end

  // Column command handed to the posted-CAS delay.
  always_comb
  begin
    colOut.cmd.valid = colEn && (cmd == dem_pkg::CMD_RD || cmd == dem_pkg::CMD_WR);
    colOut.cmd.write = (cmd == dem_pkg::CMD_WR);
    colOut.cmd.bank  = ba;
    colOut.cmd.col   = addr[dem_pkg::COL_W-1:0];
  end
endmodule : dem_cmd_decode

// file: design/dem_posted_cas.sv
// Posted-CAS delay line that holds column commands for the additive latency.
`timescale 1ns/100ps
module dem_posted_cas #(
  parameter int MAX_AL = 6
) (
  // Clock and reset.
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // Current additive latency, already limited to MAX_AL.
  input  wire logic [dem_pkg::AL_W-1:0] al,
  // Commands in and out.
  dem_col_if.dst                      newCmd,
  dem_col_if.src                      issued
);
  typedef struct packed {
    dem_pkg::dem_col_t [MAX_AL-1:0] slot;
  } dem_pc_state_t;

  dem_pc_state_t stateQ;
  dem_pc_state_t stateD;

  // hold for the additive latency
  // Slots shift toward zero each clock; a new command enters at slot
  // al-1 and so leaves slot zero exactly al clocks later. A latency
  // change while commands are in flight may reorder them.
  always_comb
  begin
    stateD = '0;
    for (int i = 0; i < MAX_AL - 1; i++)
    begin
      stateD.slot[i] = stateQ.slot[i+1];
    end
    if (al != '0)
    begin
      stateD.slot[int'(al) - 1] = newCmd.cmd;
    end
    issued.cmd = (al == '0) ? newCmd.cmd : stateQ.slot[0];
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      stateQ <= '0;
    else
      stateQ <= stateD;
  end
endmodule : dem_posted_cas

// file: verif/dem_ext_mode_act_sva.sv
// Checker for the extended mode, activate and posted-CAS block.
`timescale 1ns/100ps
module dem_ext_mode_act_sva #(
  parameter int MAX_AL = 6
) (
  // Clock, reset and command pins.
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        cke,
  input wire logic        csN,
  input wire logic        rasN,
  input wire logic        casN,
  input wire logic        weN,
  input wire logic [1:0]  ba,
  input wire logic [12:0] addr,
  input wire logic        odtPin,
  input wire logic [2:0]  casLatency,
  // Watched outputs.
  input wire logic [12:0] extMode1,
  input wire logic        dllEnabled,
  input wire logic        dllLocked,
  input wire logic        selfRefresh,
  input wire logic        termActive,
  input wire logic [3:0]  bankOpen,
  input wire logic [3:0]  readLatency,
  input wire logic [3:0]  writeLatency,
  input wire logic        issueValid,
  input wire logic [1:0]  issueBank,
  input wire logic        modeRejected,
  input wire logic        modeWithTerm,
  input wire logic        colTooClose,
  input wire logic        readBeforeLock
);
  logic       ckeQ;
  logic       colQ;
  logic       take;
  logic       mode;
  logic       col;
  logic [2:0] al;

  // Command qualifiers; the enable history restarts low so no command counts right at release.
  assign take = cke && ckeQ && !selfRefresh && !csN;
  assign mode = take && !rasN && !casN && !weN;
  assign col  = take && rasN && !casN;
  assign al   = (extMode1[5:3] == 3'h7) ? 3'(MAX_AL) : extMode1[5:3];

  // History of the enable pin and of the last column command.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ckeQ <= 1'b0;
      colQ <= 1'b0;
    end
    else
    begin
      ckeQ <= cke;
      colQ <= col;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_emr1_write:
    assert property (mode && ba == 2'h1 && bankOpen == 4'h0 |=> extMode1 == $past(addr))
    else $error("register one write not stored");
  chk_mode_reject:
    assert property (mode && ba != 2'h0 && bankOpen != 4'h0
      |=> modeRejected && extMode1 == $past(extMode1))
    else $error("mode write with open bank not refused");
  chk_sr_off:
    assert property (selfRefresh |-> !dllEnabled && !termActive)
    else $error("DLL or termination on in self-refresh");
  chk_dll_back:
    assert property ($fell(selfRefresh) && !extMode1[0] |=> dllEnabled)
    else $error("DLL not back after self-refresh");
  chk_mode_term:
    assert property (mode && ba != 2'h0 && bankOpen == 4'h0 && odtPin |=> modeWithTerm)
    else $error("mode write with termination not flagged");
  chk_act_open:
    assert property (take && !rasN && casN && weN |=> bankOpen[$past(ba)])
    else $error("activated bank not open");
  chk_posted_issue:
    assert property (col && al == 3'h2 && $stable(extMode1)
      |-> ##3 issueValid && issueBank == $past(ba, 3))
    else $error("column not issued after additive latency");
  chk_col_close:
    assert property (col && colQ |=> colTooClose)
    else $error("close column commands not flagged");
  chk_read_lock:
    assert property (col && weN && !dllLocked |=> readBeforeLock)
    else $error("read before lock not flagged");
  chk_latency_sum:
    assert property ($stable(extMode1) && $stable(casLatency)
      |=> readLatency == 4'($past(al)) + 4'($past(casLatency))
          && writeLatency == readLatency - 4'h1)
    else $error("latency sums wrong");
endmodule : dem_ext_mode_act_sva

bind dem_ext_mode_act dem_ext_mode_act_sva #(.MAX_AL(MAX_AL)) u_sva (
  .mclk, .rst_n, .cke, .csN, .rasN, .casN, .weN, .ba, .addr, .odtPin, .casLatency,
  .extMode1, .dllEnabled, .dllLocked, .selfRefresh, .termActive, .bankOpen,
  .readLatency, .writeLatency, .issueValid, .issueBank, .modeRejected,
  .modeWithTerm, .colTooClose, .readBeforeLock
);

// file: verif/dem_ctrl_model.sv
// Memory controller model that drives the command pins of the block.
`timescale 1ns/100ps
module dem_ctrl_model (
  // Clock.
  input  wire logic   mclk,
  // Command pins towards the block.
  output logic        cke,
  output logic        csN,
  output logic        rasN,
  output logic        casN,
  output logic        weN,
  output logic [1:0]  ba,
  output logic [12:0] addr,
  output logic        odtPin
);
  // Pins idle at power-up with the enable and termination low.
  initial
  begin
    {cke, odtPin} = 2'h0;
    {csN, rasN, casN, weN} = 4'hF;
    ba = 2'h0;
    addr = 13'h0000;
  end

  // spacing and order
  // Gap 0 leaves the pins for a back-to-back command; otherwise deselect and flip the
  // address so stale values are never mistaken for held ones.
  task automatic send(input logic [3:0] cmd, input logic [1:0] b, input logic [12:0] a,
                      input int gap);
    @(negedge mclk);
    {csN, rasN, casN, weN} = cmd;
    ba = b;
    addr = a;
    if (gap > 0)
    begin
      @(negedge mclk);
      csN = 1'b1;
      ba = ~b;
      addr = ~a;
      repeat (gap) @(negedge mclk);
    end
  endtask : send

  // Refresh pattern with the enable dropping enters self-refresh.
  task automatic enterSr();
    @(negedge mclk);
    {csN, rasN, casN, weN} = 4'h1;
    cke = 1'b0;
    @(negedge mclk);
    csN = 1'b1;
    repeat (2) @(negedge mclk);
  endtask : enterSr

  task automatic setCke(input logic v);
    @(negedge mclk);
    cke = v;
    repeat (3) @(negedge mclk);
  endtask : setCke

  task automatic setOdt(input logic v);
    @(negedge mclk);
    odtPin = v;
  endtask : setOdt
endmodule : dem_ctrl_model

// file: verif/testbench.sv
// Self-checking bench for the extended mode, activate and posted-CAS block.
`timescale 1ns/100ps
module testbench;
  localparam logic [3:0] MODE = 4'h0;
  localparam logic [3:0] ACT  = 4'h3;
  localparam logic [3:0] RD   = 4'h5;
  localparam logic [3:0] WR   = 4'h4;
  localparam logic [3:0] PRE  = 4'h2;

  logic        mclk, rst_n, cke, csN, rasN, casN, weN, odtPin, burstInterleave;
  logic [1:0]  ba, odtSetting, issueBank;
  logic [12:0] addr, extMode1, extMode2, extMode3, issueRow;
  logic [2:0]  casLatency, addLatency;
  logic [3:0]  bankOpen, readLatency, writeLatency;
  logic [6:0]  issueSegment;
  logic [7:0]  burstCols;
  logic        dllEnabled, dllLocked, driveWeak, strobeCompDisabled, alReserved;
  logic        selfRefresh, termActive, issueValid, issueWrite;
  wire  [5:0]  pulses;
  logic [30:0] cap;
  int          nP [6];
  int          nIss, errCount, testsRun, cycles;

  dem_ext_mode_act u_dut (
    .mclk, .rst_n, .cke, .csN, .rasN, .casN, .weN, .ba, .addr, .odtPin, .casLatency,
    .burstInterleave, .extMode1, .extMode2, .extMode3, .dllEnabled, .dllLocked,
    .driveWeak, .odtSetting, .addLatency, .strobeCompDisabled, .alReserved, .selfRefresh,
    .termActive, .bankOpen, .readLatency, .writeLatency, .issueValid, .issueWrite,
    .issueBank, .issueRow, .issueSegment, .burstCols, .modeRejected(pulses[0]),
    .modeReservedSet(pulses[1]), .modeWithTerm(pulses[2]), .colToClosed(pulses[3]),
    .colTooClose(pulses[4]), .readBeforeLock(pulses[5])
  );

  dem_ctrl_model u_ctrl (.mclk, .cke, .csN, .rasN, .casN, .weN, .ba, .addr, .odtPin);

  // Free-running clock.
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Count one-cycle flags and keep the last issued column; also cut a hang short.
  always @(posedge mclk)
  begin
    for (int i = 0; i < 6; i++)
      if (pulses[i] === 1'b1) nP[i]++;
    if (issueValid === 1'b1)
    begin
      nIss++;
      cap = {issueWrite, issueBank, issueRow, issueSegment, burstCols};
    end
    cycles++;
    if (cycles == 5000)
    begin
      errCount++;
      completeRun();
    end
  end

  task automatic check(input string name, input logic [30:0] seen, input logic [30:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errCount++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic completeRun();
    $display("Checks %0d, mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : completeRun

  // Main sequence: power-up, initialisation, then each awkward case in turn.
  initial
  begin
    rst_n = 1'b0;
    casLatency = 3'h3;
    burstInterleave = 1'b0;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    u_ctrl.setCke(1'b1);
    u_ctrl.send(ACT, 2'h0, 13'h0000, 0);
    u_ctrl.send(RD, 2'h0, 13'h0000, 2);
    check("readBeforeLock", nP[5], 1);
    u_ctrl.send(PRE, 2'h0, 13'h0400, 2);
    check("bankOpen", bankOpen, 0);
    u_ctrl.send(MODE, 2'h2, 13'h0080, 2);
    u_ctrl.send(MODE, 2'h3, 13'h0000, 2);
    u_ctrl.send(MODE, 2'h1, 13'h0000, 2);
    u_ctrl.send(MODE, 2'h0, 13'h0100, 2);
    check("extMode2", extMode2, 13'h0080);
    check("extMode3", extMode3, 13'h0000);
    check("dllEnabled", dllEnabled, 1);
    repeat (190) @(negedge mclk);
    check("dllLocked", dllLocked, 0);
    repeat (15) @(negedge mclk);
    check("dllLocked", dllLocked, 1);
    u_ctrl.send(MODE, 2'h1, 13'h0380, 2);
    u_ctrl.send(MODE, 2'h1, 13'h0456, 2);
    check("fields", {driveWeak, odtSetting, addLatency, strobeCompDisabled, dllEnabled},
          8'hEB);
    check("latency", {readLatency, writeLatency}, 8'h54);
    u_ctrl.send(MODE, 2'h2, 13'h0081, 2);
    u_ctrl.send(MODE, 2'h3, 13'h0001, 2);
    check("reservedSet", nP[1], 2);
    u_ctrl.send(MODE, 2'h3, 13'h0000, 2);
    u_ctrl.setOdt(1'b1);
    u_ctrl.send(MODE, 2'h2, 13'h0080, 2);
    check("modeWithTerm", nP[2], 1);
    check("termActive", termActive, 1);
    u_ctrl.enterSr();
    check("srEntry", {selfRefresh, dllEnabled, termActive}, 3'h4);
    u_ctrl.setCke(1'b1);
    check("srExit", {selfRefresh, dllEnabled}, 2'h1);
    u_ctrl.setOdt(1'b0);
    for (int i = 0; i < 2; i++)
    begin
      burstInterleave = i[0];
      u_ctrl.send(ACT, 2'h1, 13'h1ABC, 0);
      u_ctrl.send(i[0] ? WR : RD, 2'h1, 13'h00D5, 4);
      check("issue", cap, {i[0], 2'h1, 13'h1ABC, 7'h35, i[0] ? 8'hB1 : 8'h39});
      u_ctrl.send(PRE, 2'h1, 13'h0000, 2);
    end
    check("issueCount", nIss, 3);
    u_ctrl.send(ACT, 2'h1, 13'h0000, 2);
    u_ctrl.send(RD, 2'h1, 13'h0000, 0);
    u_ctrl.send(RD, 2'h1, 13'h0004, 2);
    u_ctrl.send(RD, 2'h2, 13'h0000, 2);
    u_ctrl.send(MODE, 2'h1, 13'h0000, 2);
    check("colTooClose", nP[4], 1);
    check("colToClosed", nP[3], 1);
    check("modeRejected", nP[0], 1);
    check("extMode1", extMode1, 13'h0456);
    u_ctrl.send(PRE, 2'h0, 13'h0400, 2);
    for (int i = 0; i < 8; i++)
    begin
      u_ctrl.send(MODE, 2'h1, 13'(i * 8), 2);
      check("alCode", {alReserved, readLatency}, {i == 7, 4'(i == 7 ? 6 : i) + 4'h3});
    end
    completeRun();
  end
endmodule : testbench
